// File: logic/dec_pkg.sv
// constants, register map and field layout of the edge counter
package dec_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int          CH_NUM      = 4;
  localparam int          CLK_NS      = 100;
  localparam int          UNIT_NS     = 50000;
  localparam int          UNIT_CYC    = (UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          UNIT_CW     = 16;
  localparam int          FLT_CW      = 9;

  // ----------------------------------------------------------------
  // register map (word offsets inside a channel, address bits 5:2, stride 0x40)
  // ----------------------------------------------------------------
  localparam logic [3:0]  R_CTRL      = 4'h0;
  localparam logic [3:0]  R_LOW       = 4'h1;
  localparam logic [3:0]  R_HIGH      = 4'h2;
  localparam logic [3:0]  R_START     = 4'h3;
  localparam logic [3:0]  R_CMP0      = 4'h4;
  localparam logic [3:0]  R_CMP1      = 4'h5;
  localparam logic [3:0]  R_CMPS      = 4'h6;
  localparam logic [3:0]  R_VALUE     = 4'h7;
  localparam logic [3:0]  R_STAT      = 4'h8;
  localparam logic [3:0]  R_LAST      = 4'h8;
  localparam logic [3:0]  R_GCTRL     = 4'h0;
  localparam logic [3:0]  R_GSTAT     = 4'h1;
  localparam int          A_GLOB      = 8;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int          F_EN        = 0;
  localparam int          F_DLY       = 1;
  localparam int          F_EDGE      = 4;
  localparam int          F_DIR       = 6;
  localparam int          F_STOP      = 7;
  localparam int          F_OUT       = 8;
  localparam int          F_AUX       = 11;
  localparam int          F_SWG       = 13;
  localparam int          F_LOAD      = 14;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_3FFF;
  localparam logic [31:0] CTRL_RST    = 32'h0000_200B;
  localparam logic [31:0] LOW_RST     = 32'h0000_0000;
  localparam logic [31:0] HI_SIGNED   = 32'h7FFF_FFFF;
  localparam logic [31:0] HI_UNSIGNED = 32'hFFFF_FFFF;
  localparam logic [31:0] START_RST   = 32'h0000_0000;
  localparam logic [31:0] CMP0_RST    = 32'h0000_0000;
  localparam logic [31:0] CMP1_RST    = 32'h0000_000A;
  localparam logic [31:0] CMPS_RST    = 32'h0000_000A;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1,
                            EDGE_BOTH = 2'h2} dec_edge_t;
  typedef enum logic [1:0] {AUX_NONE = 2'h0, AUX_GATE = 2'h1,
                            AUX_DIR = 2'h2} dec_aux_t;
  typedef enum logic [2:0] {OUT_LOW = 3'h0, OUT_HIGH = 3'h1,
                            OUT_IN = 3'h2, OUT_OUTSIDE = 3'h3,
                            OUT_UPPER = 3'h4, OUT_LOWER = 3'h5} dec_out_t;

  // filter delay in 0.05 ms units: 0.05 0.1 0.4 0.8 1.6 3.2 12.8 20 ms
  function automatic logic [FLT_CW-1:0] dly_units(input logic [2:0] s);
    case (s)
      3'h0:    dly_units = 9'h001;
      3'h1:    dly_units = 9'h002;
      3'h2:    dly_units = 9'h008;
      3'h3:    dly_units = 9'h010;
      3'h4:    dly_units = 9'h020;
      3'h5:    dly_units = 9'h040;
      3'h6:    dly_units = 9'h100;
      default: dly_units = 9'h190;
    endcase
  endfunction

endpackage

// File: logic/dec_input_filter.sv
// input delay filter for one digital input
`timescale 1ns/10ps
module dec_input_filter (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     tick,
  input  wire logic [dec_pkg::FLT_CW-1:0] units,
  input  wire logic                     din,
  output logic                          level_q
);

  logic [dec_pkg::FLT_CW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // stability count
  // ----------------------------------------------------------------
  // accept after units+1 ticks, so the level held longer than the delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else if (din == level_q) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q >= units) begin
        level_q <= din;
        cnt_q   <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// File: logic/dec_compare.sv
// comparison function that drives the output-state bit
`timescale 1ns/10ps
module dec_compare #(
  parameter bit SIGNED_VARIANT = 1'b1
) (
  input  wire logic [31:0] value,
  input  wire logic [31:0] low,
  input  wire logic [31:0] high,
  input  wire logic [31:0] cmp0,
  input  wire logic [31:0] cmp1,
  input  wire logic [31:0] cmps,
  input  wire logic [2:0]  func,
  output logic             state
);

  function automatic logic le(input logic [31:0] a, input logic [31:0] b);
    le = SIGNED_VARIANT ? ($signed(a) <= $signed(b)) : (a <= b);
  endfunction

  wire in_win = le(cmp0, value) & le(value, cmp1);
  wire upper  = le(cmps, value) & le(value, high);
  wire lower  = le(low, value) & le(value, cmps);

  // ----------------------------------------------------------------
  // function select
  // ----------------------------------------------------------------
  always_comb begin
    case (dec_pkg::dec_out_t'(func))
      dec_pkg::OUT_LOW:     state = 1'b0;
      dec_pkg::OUT_HIGH:    state = 1'b1;
      dec_pkg::OUT_IN:      state = in_win;
      dec_pkg::OUT_OUTSIDE: state = ~in_win;
      dec_pkg::OUT_UPPER:   state = upper;
      dec_pkg::OUT_LOWER:   state = lower;
      default:              state = 1'b0;
    endcase
  end

endmodule

// File: logic/dec_edge_counter.sv
// multi-channel filtered edge counter with AXI4-Lite registers
`timescale 1ns/10ps
module dec_edge_counter #(
  parameter bit SIGNED_VARIANT = 1'b1,
  parameter int UNIT_CYCLES    = dec_pkg::UNIT_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [31:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [31:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [dec_pkg::CH_NUM-1:0] count_in,
  input  wire logic [dec_pkg::CH_NUM-1:0] aux_in,
  input  wire logic                      input_read_instant,
  output logic [dec_pkg::CH_NUM-1:0]     compare_output_state
);

  localparam int N = dec_pkg::CH_NUM;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]                ctrl_q  [N];
  logic [31:0]                low_q   [N];
  logic [31:0]                high_q  [N];
  logic [31:0]                start_q [N];
  logic [31:0]                cmp0_q  [N];
  logic [31:0]                cmp1_q  [N];
  logic [31:0]                cmps_q  [N];
  logic [31:0]                fb_val_q[N];
  logic [4:0]                 fb_sts_q[N];
  logic [N-1:0]               fast_ch;
  logic                       iso_req_q;
  logic                       iso_act_q;
  logic [dec_pkg::UNIT_CW-1:0] pre_q;
  logic                       tick_q;
  logic [31:0]                awaddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic [31:0]                rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // delay time base: one tick per 0.05 ms
  // ----------------------------------------------------------------
  localparam logic [dec_pkg::UNIT_CW-1:0] PRE_TOP =
    dec_pkg::UNIT_CW'(UNIT_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == PRE_TOP);
      pre_q  <= (pre_q == PRE_TOP) ? '0 : pre_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wire       wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       wr_glob = awaddr_q[dec_pkg::A_GLOB];
  wire [1:0] wr_ch   = awaddr_q[7:6];
  wire [3:0] wr_reg  = awaddr_q[5:2];
  wire       wr_hi0  = (awaddr_q[31:9] == 23'h000000);
  wire       wr_map  = wr_hi0 & (wr_glob ? (wr_reg <= dec_pkg::R_GSTAT)
                                         : (wr_reg <= dec_pkg::R_LAST));
  wire       wr_ok   = wr_go & wr_map;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // global control and isochronous gating
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iso_req_q <= 1'b0;
      iso_act_q <= 1'b0;
    end else begin
      if (wr_ok && wr_glob && wr_reg == dec_pkg::R_GCTRL && wstrb_q[0]) begin
        iso_req_q <= wdata_q[0];
      end
      // needs a channel on the shortest delay
      iso_act_q <= iso_req_q & (|fast_ch);
    end
  end

  // snapshot every cycle, or only at the read instant while iso_act_q is set
  wire fb_upd = ~iso_act_q | input_read_instant;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_ch
    wire [31:0] c       = ctrl_q[g];
    wire        sel     = wr_ok & ~wr_glob & (wr_ch == 2'(g));
    wire [31:0] wv      = merge('0, wdata_q, wstrb_q);
    wire        ld      = sel & (wr_reg == dec_pkg::R_CTRL) & wstrb_q[1] &
                          wdata_q[dec_pkg::F_LOAD];
    wire [2:0]  dsel    = c[dec_pkg::F_DLY +: 3];
    wire [1:0]  esel    = c[dec_pkg::F_EDGE +: 2];
    wire [1:0]  aux_fn  = c[dec_pkg::F_AUX +: 2];
    logic       cnt_f;
    logic       aux_f;
    logic       prev_q;
    logic       stop_q;
    logic [31:0] val_q;
    logic       cmp_now;

    assign fast_ch[g] = c[dec_pkg::F_EN] & (dsel == 3'h0);

    // register writes; low limit fixed at zero on unsigned variants
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctrl_q[g]  <= dec_pkg::CTRL_RST;
        low_q[g]   <= dec_pkg::LOW_RST;
        // default high limit is the variant maximum
        high_q[g]  <= SIGNED_VARIANT ? dec_pkg::HI_SIGNED
                                     : dec_pkg::HI_UNSIGNED;
        start_q[g] <= dec_pkg::START_RST;
        cmp0_q[g]  <= dec_pkg::CMP0_RST;
        cmp1_q[g]  <= dec_pkg::CMP1_RST;
        cmps_q[g]  <= dec_pkg::CMPS_RST;
      end else if (sel) begin
        case (wr_reg)
          dec_pkg::R_CTRL:  ctrl_q[g]  <= merge(c, wdata_q, wstrb_q) &
                                          dec_pkg::CTRL_MASK;
          // unsigned variant keeps low limit at zero
          dec_pkg::R_LOW:   low_q[g]   <= SIGNED_VARIANT ?
                                          merge(low_q[g], wv | wdata_q &
                                          32'h0000_0000, wstrb_q) :
                                          dec_pkg::LOW_RST;
          dec_pkg::R_HIGH:  high_q[g]  <= merge(high_q[g], wdata_q,
                                                wstrb_q);
          dec_pkg::R_START: start_q[g] <= merge(start_q[g], wdata_q,
                                                wstrb_q);
          dec_pkg::R_CMP0:  cmp0_q[g]  <= merge(cmp0_q[g], wdata_q,
                                                wstrb_q);
          dec_pkg::R_CMP1:  cmp1_q[g]  <= merge(cmp1_q[g], wdata_q,
                                                wstrb_q);
          dec_pkg::R_CMPS:  cmps_q[g]  <= merge(cmps_q[g], wdata_q,
                                                wstrb_q);
          default:          ctrl_q[g]  <= c;
        endcase
      end
    end

    dec_input_filter u_cnt_flt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_q),
      .units   (dec_pkg::dly_units(dsel)),
      .din     (count_in[g]),
      .level_q (cnt_f)
    );

    dec_input_filter u_aux_flt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_q),
      .units   (dec_pkg::dly_units(dsel)),
      .din     (aux_in[g]),
      .level_q (aux_f)
    );

    wire hw_gate  = (aux_fn == dec_pkg::AUX_GATE) ? aux_f : 1'b1;
    // enable is part of the controlling gate
    wire ctl_gate = c[dec_pkg::F_EN] & c[dec_pkg::F_SWG] & hw_gate;
    wire aux_dir  = (aux_fn == dec_pkg::AUX_DIR);
    wire down     = aux_dir ? aux_f : c[dec_pkg::F_DIR];
    // counting down by aux swaps the edge
    wire flip     = aux_dir & aux_f;
    wire rise     = cnt_f & ~prev_q;
    wire fall     = ~cnt_f & prev_q;
    wire hit      = (esel == dec_pkg::EDGE_BOTH) ? (rise | fall) :
                    ((esel == dec_pkg::EDGE_FALL) ^ flip) ? fall : rise;
    wire count_en = ctl_gate & ~stop_q & hit;
    wire at_lim   = down ? (val_q == low_q[g]) : (val_q == high_q[g]);

    // one 32-bit counter, sign only matters to compares
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_q <= 1'b0;
        stop_q <= 1'b0;
        val_q  <= dec_pkg::START_RST;
      end else begin
        prev_q <= cnt_f;
        // restart needs the controlling gate closed
        if (!ctl_gate) begin
          stop_q <= 1'b0;
        end
        if (ld) begin
          val_q <= start_q[g];
        end else if (count_en) begin
          if (at_lim) begin
            val_q <= down ? high_q[g] : low_q[g];
            if (c[dec_pkg::F_STOP] && ctl_gate) begin
              stop_q <= 1'b1;
            end
          end else begin
            val_q <= down ? val_q - 32'h0000_0001 : val_q + 32'h0000_0001;
          end
        end
      end
    end

    dec_compare #(
      .SIGNED_VARIANT (SIGNED_VARIANT)
    ) u_cmp (
      .value (val_q),
      .low   (low_q[g]),
      .high  (high_q[g]),
      .cmp0  (cmp0_q[g]),
      .cmp1  (cmp1_q[g]),
      .cmps  (cmps_q[g]),
      .func  (c[dec_pkg::F_OUT +: 3]),
      .state (cmp_now)
    );

    // feedback snapshot; aux level always reported
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        fb_val_q[g]             <= dec_pkg::START_RST;
        fb_sts_q[g]             <= '0;
        compare_output_state[g] <= 1'b0;
      end else if (fb_upd) begin
        fb_val_q[g]             <= val_q;
        fb_sts_q[g]             <= {down, stop_q, ctl_gate & ~stop_q,
                                    aux_f, cmp_now};
        compare_output_state[g] <= cmp_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire       rd_glob = s_axi_araddr[dec_pkg::A_GLOB];
  wire [1:0] rd_ch   = s_axi_araddr[7:6];
  wire [3:0] rd_reg  = s_axi_araddr[5:2];
  wire       rd_map  = (s_axi_araddr[31:9] == 23'h000000) &
                       (rd_glob ? (rd_reg <= dec_pkg::R_GSTAT)
                                : (rd_reg <= dec_pkg::R_LAST));

  always_comb begin
    rd_word = '0;
    if (rd_glob) begin
      rd_word = (rd_reg == dec_pkg::R_GCTRL) ? {31'h0, iso_req_q}
                                             : {31'h0, iso_act_q};
    end else begin
      case (rd_reg)
        dec_pkg::R_CTRL:  rd_word = ctrl_q[rd_ch];
        dec_pkg::R_LOW:   rd_word = low_q[rd_ch];
        dec_pkg::R_HIGH:  rd_word = high_q[rd_ch];
        dec_pkg::R_START: rd_word = start_q[rd_ch];
        dec_pkg::R_CMP0:  rd_word = cmp0_q[rd_ch];
        dec_pkg::R_CMP1:  rd_word = cmp1_q[rd_ch];
        dec_pkg::R_CMPS:  rd_word = cmps_q[rd_ch];
        dec_pkg::R_VALUE: rd_word = fb_val_q[rd_ch];
        dec_pkg::R_STAT:  rd_word = {27'h0, fb_sts_q[rd_ch]};
        default:          rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_map ? rd_word : '0;
      s_axi_rresp   <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: sim/dec_edge_counter_checker.sv
// port protocol assertions for the edge counter
`timescale 1ns/10ps
module dec_edge_counter_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [3:0]  compare_output_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data unstable");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken early");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken early");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write reply");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read reply");
  property p_r_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000_0200
      |-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("no slverr");
  property p_rst_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
      && compare_output_state == 4'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset state wrong");
endmodule
bind dec_edge_counter dec_edge_counter_checker i_dec_edge_counter_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .compare_output_state(compare_output_state));

// File: sim/dec_cpu_model.sv
// controller cycle model issuing the input read instant
`timescale 1ns/10ps
module dec_cpu_model #(
  parameter int PERIOD = 50
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      input_read_instant
);
  int cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || cnt_q == PERIOD - 1) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
    input_read_instant <= aresetn && cnt_q == PERIOD - 1;
  end
endmodule

// File: sim/test_digital_input_edge_counter.sv
// self-checking bench for the edge counter
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); miscompares++; end end
module test_digital_input_edge_counter;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, iri;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  cnt_in = 4'h0, aux = 4'h0, cos;
  int          compares = 0, miscompares = 0;
  logic [31:0] rv [8] = '{32'h200B, 32'h0, 32'h7FFF_FFFF, 32'h0, 32'h0,
                          32'hA, 32'hA, 32'h0};
  logic [31:0] ev [4] = '{32'h4, 32'h7FFF_FFFC, 32'h0, 32'h0};
  logic [5:0]  ce = 6'b100110;
  always #50 aclk = ~aclk;
  dec_edge_counter #(.SIGNED_VARIANT(1'b1), .UNIT_CYCLES(2)) i_dec_edge_counter (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_in(cnt_in), .aux_in(aux),
    .input_read_instant(iri), .compare_output_state(cos));
  dec_cpu_model #(.PERIOD(50)) i_dec_cpu_model (
    .aclk(aclk), .aresetn(aresetn), .input_read_instant(iri));
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready === 1'b1;
      w_t = wvalid && wready === 1'b1;
      b_t = bvalid === 1'b1;
      rs = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask
  task automatic rd_(input logic [31:0] a);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready === 1'b1;
      r_t = rvalid === 1'b1;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask
  // filtered pulses, each level held well past the shortest delay
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge aclk); cnt_in <= m;
      repeat (12) @(posedge aclk);
      cnt_in <= 4'h0;
      repeat (12) @(posedge aclk);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_(32'(i * 4));
      `CHK("reset value", rv[i], rd)
    end
    rd_(32'h200);
    `CHK("unmapped resp", 2'h2, rs)
    // ch0 up rising, ch1 down falling, ch2 stop at high 2, ch3 disabled
    wr(32'h00, 32'h2001);
    wr(32'h40, 32'h2051);
    wr(32'h88, 32'h2);
    wr(32'h80, 32'h2081);
    wr(32'hC0, 32'h2000);
    pulse(4'hF, 4);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd_(32'(i * 64 + 28));
      `CHK("value", ev[i], rd)
    end
    rd_(32'hA0);
    `CHK("stopped", 1'b1, rd[3])
    wr(32'h80, 32'h0081);
    wr(32'h80, 32'h2081);
    pulse(4'h4, 1);
    rd_(32'h9C);
    `CHK("restart", 32'h1, rd)
    for (int f = 0; f < 6; f++) begin
      wr(32'h00, 32'h2001 | (32'(f) << 8));
      repeat (4) @(posedge aclk);
      `CHK("cmp state", ce[f], cos[0])
    end
    // one-cycle glitch is shorter than the delay and must not count
    @(posedge aclk); cnt_in <= 4'h1;
    @(posedge aclk); cnt_in <= 4'h0;
    repeat (20) @(posedge aclk);
    rd_(32'h1C);
    `CHK("glitch", 32'h4, rd)
    // start value inside the limits, loaded on the disabled channel
    wr(32'hCC, 32'h7);
    wr(32'hC0, 32'h4000);
    rd_(32'hDC);
    `CHK("start load", 32'h7, rd)
    aux <= 4'h2;
    repeat (20) @(posedge aclk);
    rd_(32'h60);
    `CHK("aux level", 1'b1, rd[1])
    // gate closed by low aux blocks the count
    wr(32'h00, 32'h2801);
    pulse(4'h1, 1);
    aux <= 4'h3;
    repeat (20) @(posedge aclk);
    pulse(4'h1, 1);
    rd_(32'h1C);
    `CHK("aux gate", 32'h5, rd)
    wr(32'h00, 32'h3001);
    pulse(4'h1, 1);
    rd_(32'h1C);
    `CHK("aux down", 32'h4, rd)
    wr(32'h100, 32'h1);
    rd_(32'h104);
    `CHK("iso active", 1'b1, rd[0])
    // feedback frozen between read instants, refreshed at the next one
    do @(posedge aclk); while (iri !== 1'b1);
    pulse(4'h1, 1);
    rd_(32'h1C);
    `CHK("iso hold", 32'h4, rd)
    do @(posedge aclk); while (iri !== 1'b1);
    repeat (2) @(posedge aclk);
    rd_(32'h1C);
    `CHK("iso update", 32'h3, rd)
    wrap_up();
  end
endmodule
